// ===== logic/dioc_cfg.svh
// register map, field positions, reset values and timing figures of the channel block
`ifndef DIOC_CFG_SVH
`define DIOC_CFG_SVH
// clock rate
`define DIOC_CLK_KHZ 125000
// register byte offsets
`define DIOC_OFS_CTRL 8'h00
`define DIOC_OFS_OPEN_EN 8'h04
`define DIOC_OFS_FAULT_MODE 8'h08
`define DIOC_OFS_IDLE_MODE 8'h0C
`define DIOC_OFS_OUT_DATA 8'h10
`define DIOC_OFS_IN_STATE 8'h14
`define DIOC_OFS_SHORT_ERR 8'h18
`define DIOC_OFS_OPEN_ERR 8'h1C
`define DIOC_OFS_IRQ_STAT 8'h20
`define DIOC_OFS_IRQ_MASK 8'h24
// control field positions
`define DIOC_CTRL_SUPPLY_EN 0
`define DIOC_CTRL_INRUSH_EN 1
`define DIOC_CTRL_FILT_LO 2
`define DIOC_CTRL_EXT_LO 4
`define DIOC_CTRL_LOAD_EN 6
`define DIOC_CTRL_MANUAL 7
`define DIOC_CTRL_SWPRIO 8
`define DIOC_CTRL_W 9
// control reset: supply and load checks on, 1.0 ms filter, 1.0 ms extension
`define DIOC_CTRL_RST 9'h045
// interrupt status bits
`define DIOC_IRQ_SUPPLY 0
`define DIOC_IRQ_OVERCUR 1
`define DIOC_IRQ_SHORT 2
`define DIOC_IRQ_OPEN 3
`define DIOC_IRQ_W 4
// times in microseconds
`define DIOC_FILT0_US 100
`define DIOC_FILT1_US 1000
`define DIOC_FILT2_US 10000
`define DIOC_FILT3_US 20000
`define DIOC_EXT0_US 1000
`define DIOC_EXT1_US 15000
`define DIOC_EXT2_US 100000
`define DIOC_EXT3_US 200000
`define DIOC_INRUSH_US 100000
`endif

// ===== logic/dioc_pkg.sv
// types shared by the digital channel conditioning block
package dioc_pkg;
	// output behaviour on communication fault or idle
	typedef enum logic [1:0] {DIOC_OM_CLEAR, DIOC_OM_HOLD, DIOC_OM_HIGH} dioc_omode_t;
endpackage : dioc_pkg

// ===== logic/dioc_top.sv
// digital i/o channel conditioning and fault handling with an apb register slave
`timescale 1ns/100ps
`include "dioc_cfg.svh"

module dioc_top import dioc_pkg::*; #(
	parameter int N = 8,
	parameter int CW = 25,
	// divide first: the long times would overflow a 32-bit product
	parameter int FILT0_CYC = `DIOC_FILT0_US * (`DIOC_CLK_KHZ / 1000),
	parameter int FILT1_CYC = `DIOC_FILT1_US * (`DIOC_CLK_KHZ / 1000),
	parameter int FILT2_CYC = `DIOC_FILT2_US * (`DIOC_CLK_KHZ / 1000),
	parameter int FILT3_CYC = `DIOC_FILT3_US * (`DIOC_CLK_KHZ / 1000),
	parameter int EXT0_CYC = `DIOC_EXT0_US * (`DIOC_CLK_KHZ / 1000),
	parameter int EXT1_CYC = `DIOC_EXT1_US * (`DIOC_CLK_KHZ / 1000),
	parameter int EXT2_CYC = `DIOC_EXT2_US * (`DIOC_CLK_KHZ / 1000),
	parameter int EXT3_CYC = `DIOC_EXT3_US * (`DIOC_CLK_KHZ / 1000),
	parameter int INRUSH_CYC = `DIOC_INRUSH_US * (`DIOC_CLK_KHZ / 1000)
) (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// field pins
	input wire logic [N-1:0] din_pin,
	input wire logic supply_short_pin,
	input wire logic overcur_pin,
	input wire logic [N-1:0] load_short_pin,
	input wire logic [N-1:0] open_load_pin,
	output logic [N-1:0] dout,
	// communication state from the fieldbus side
	input wire logic comm_fault,
	input wire logic comm_idle,
	// interrupt
	output logic irq
);
	localparam int SW = 3 * N + 2;

	function automatic logic [CW-1:0] filt_lim(input logic [1:0] s);
		unique case (s)
			2'h0: filt_lim = CW'(FILT0_CYC);
			2'h1: filt_lim = CW'(FILT1_CYC);
			2'h2: filt_lim = CW'(FILT2_CYC);
			2'h3: filt_lim = CW'(FILT3_CYC);
		endcase
	endfunction : filt_lim

	function automatic logic [CW-1:0] ext_lim(input logic [1:0] s);
		unique case (s)
			2'h0: ext_lim = CW'(EXT0_CYC);
			2'h1: ext_lim = CW'(EXT1_CYC);
			2'h2: ext_lim = CW'(EXT2_CYC);
			2'h3: ext_lim = CW'(EXT3_CYC);
		endcase
	endfunction : ext_lim

	function automatic logic mode_out(input logic [1:0] m, input logic held);
		unique case (m)
			DIOC_OM_HOLD: mode_out = held;
			DIOC_OM_HIGH: mode_out = 1'b1;
			default: mode_out = 1'b0;
		endcase
	endfunction : mode_out

	// ==========================================================
	// pin synchronisers
	logic [SW-1:0] meta_r, sync_r;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			meta_r <= '0;
			sync_r <= '0;
		end else begin
			meta_r <= {din_pin, load_short_pin, open_load_pin, supply_short_pin, overcur_pin};
			sync_r <= meta_r;
		end
	end
	logic [N-1:0] din_s, short_s, open_s;
	logic supply_s, overcur_s;
	assign {din_s, short_s, open_s, supply_s, overcur_s} = sync_r;

	// ==========================================================
	// registers
	logic [`DIOC_CTRL_W-1:0] ctrl_r, ctrl_nxt;
	logic [N-1:0] open_en_r, open_en_nxt, out_data_r, out_data_nxt;
	logic [2*N-1:0] fault_mode_r, fault_mode_nxt, idle_mode_r, idle_mode_nxt;
	logic [`DIOC_IRQ_W-1:0] irq_stat_r, irq_stat_nxt, irq_mask_r, irq_mask_nxt;
	logic [31:0] prdata_nxt;
	logic pready_nxt;
	logic [N-1:0] in_cond;
	logic [N-1:0] short_err_r, short_err_nxt, open_err;
	logic supply_err, overcur_err;
	logic [`DIOC_IRQ_W-1:0] ev_lvl, ev_prev_r;
	logic access, wr;

	assign access = psel & penable & ~pready;
	assign wr = access & pwrite;

	always_comb begin
		ctrl_nxt = ctrl_r;
		open_en_nxt = open_en_r;
		fault_mode_nxt = fault_mode_r;
		idle_mode_nxt = idle_mode_r;
		out_data_nxt = out_data_r;
		irq_mask_nxt = irq_mask_r;
		prdata_nxt = prdata;
		pready_nxt = access;
		// new events win over a write-one clear in the same cycle
		irq_stat_nxt = irq_stat_r;
		if (wr && paddr == `DIOC_OFS_IRQ_STAT)
			irq_stat_nxt = irq_stat_r & ~pwdata[`DIOC_IRQ_W-1:0];
		irq_stat_nxt = irq_stat_nxt | (ev_lvl & ~ev_prev_r);
		if (wr) begin
			unique case (paddr)
				`DIOC_OFS_CTRL: ctrl_nxt = pwdata[`DIOC_CTRL_W-1:0];
				`DIOC_OFS_OPEN_EN: open_en_nxt = pwdata[N-1:0];
				`DIOC_OFS_FAULT_MODE: fault_mode_nxt = pwdata[2*N-1:0];
				`DIOC_OFS_IDLE_MODE: idle_mode_nxt = pwdata[2*N-1:0];
				`DIOC_OFS_OUT_DATA: out_data_nxt = pwdata[N-1:0];
				`DIOC_OFS_IRQ_MASK: irq_mask_nxt = pwdata[`DIOC_IRQ_W-1:0];
				default: ;
			endcase
		end
		if (access && !pwrite) begin
			unique case (paddr)
				`DIOC_OFS_CTRL: prdata_nxt = 32'(ctrl_r);
				`DIOC_OFS_OPEN_EN: prdata_nxt = 32'(open_en_r);
				`DIOC_OFS_FAULT_MODE: prdata_nxt = 32'(fault_mode_r);
				`DIOC_OFS_IDLE_MODE: prdata_nxt = 32'(idle_mode_r);
				`DIOC_OFS_OUT_DATA: prdata_nxt = 32'(out_data_r);
				`DIOC_OFS_IN_STATE: prdata_nxt = 32'(in_cond);
				`DIOC_OFS_SHORT_ERR: prdata_nxt = 32'(short_err_r);
				`DIOC_OFS_OPEN_ERR: prdata_nxt = 32'(open_err);
				`DIOC_OFS_IRQ_STAT: prdata_nxt = 32'(irq_stat_r);
				`DIOC_OFS_IRQ_MASK: prdata_nxt = 32'(irq_mask_r);
				default: prdata_nxt = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_r <= `DIOC_CTRL_RST;
			open_en_r <= '0;
			fault_mode_r <= '0;
			idle_mode_r <= '0;
			out_data_r <= '0;
			irq_stat_r <= '0;
			irq_mask_r <= '0;
			prdata <= 32'h0000_0000;
			pready <= 1'b0;
		end else begin
			ctrl_r <= ctrl_nxt;
			open_en_r <= open_en_nxt;
			fault_mode_r <= fault_mode_nxt;
			idle_mode_r <= idle_mode_nxt;
			out_data_r <= out_data_nxt;
			irq_stat_r <= irq_stat_nxt;
			irq_mask_r <= irq_mask_nxt;
			prdata <= prdata_nxt;
			pready <= pready_nxt;
		end
	end
	// unmapped addresses read zero, writes are dropped; no bus error
	assign pslverr = 1'b0;

	// ==========================================================
	// input conditioning per channel
	logic [CW-1:0] flim, elim;
	assign flim = filt_lim(ctrl_r[`DIOC_CTRL_FILT_LO +: 2]);
	assign elim = ext_lim(ctrl_r[`DIOC_CTRL_EXT_LO +: 2]);

	for (genvar i = 0; i < N; i++) begin : g_in
		logic cand_r, cand_nxt, filt_r, filt_nxt, hold_r, hold_nxt;
		logic [CW-1:0] st_r, st_nxt, ex_r, ex_nxt;
		always_comb begin
			cand_nxt = cand_r;
			st_nxt = st_r;
			filt_nxt = filt_r;
			ex_nxt = ex_r;
			hold_nxt = hold_r;
			if (din_s[i] != cand_r) begin
				cand_nxt = din_s[i];
				st_nxt = '0;
			end else if (st_r >= flim - CW'(1)) begin
				filt_nxt = cand_r;
			end else begin
				st_nxt = st_r + CW'(1);
			end
			// extension restarts on every active cycle, counts down after release
			if (filt_r) begin
				ex_nxt = elim - CW'(1);
				hold_nxt = 1'b1;
			end else if (ex_r != '0) begin
				ex_nxt = ex_r - CW'(1);
			end else begin
				hold_nxt = 1'b0;
			end
		end
		always_ff @(posedge pclk or negedge presetn) begin
			if (!presetn) begin
				cand_r <= 1'b0;
				st_r <= '0;
				filt_r <= 1'b0;
				ex_r <= '0;
				hold_r <= 1'b0;
			end else begin
				cand_r <= cand_nxt;
				st_r <= st_nxt;
				filt_r <= filt_nxt;
				ex_r <= ex_nxt;
				hold_r <= hold_nxt;
			end
		end
		assign in_cond[i] = hold_r;
	end

	// ==========================================================
	// error detection
	logic [CW-1:0] inrush_r, inrush_nxt;
	logic inrush_done;
	assign inrush_done = (inrush_r == CW'(INRUSH_CYC));
	assign supply_err = supply_s & ctrl_r[`DIOC_CTRL_SUPPLY_EN];
	// window is timed from power-up even if enabled later
	assign overcur_err = overcur_s & (inrush_done | ~ctrl_r[`DIOC_CTRL_INRUSH_EN]);
	assign open_err = open_s & open_en_r;

	always_comb begin
		inrush_nxt = inrush_done ? inrush_r : inrush_r + CW'(1);
		if (ctrl_r[`DIOC_CTRL_MANUAL])
			short_err_nxt = short_err_r | (short_s & {N{ctrl_r[`DIOC_CTRL_LOAD_EN]}});
		else
			short_err_nxt = short_s & {N{ctrl_r[`DIOC_CTRL_LOAD_EN]}};
	end

	assign ev_lvl = {|open_err, |short_err_r, overcur_err, supply_err};

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			inrush_r <= '0;
			short_err_r <= '0;
			ev_prev_r <= '0;
		end else begin
			inrush_r <= inrush_nxt;
			short_err_r <= short_err_nxt;
			ev_prev_r <= ev_lvl;
		end
	end

	// ==========================================================
	// output drive and interrupt
	logic [N-1:0] dout_nxt;
	logic irq_nxt;
	always_comb begin
		irq_nxt = |(irq_stat_nxt & irq_mask_r);
		for (int k = 0; k < N; k++) begin
			if (!comm_fault && !comm_idle)
				dout_nxt[k] = out_data_r[k];
			else if (!ctrl_r[`DIOC_CTRL_SWPRIO])
				dout_nxt[k] = 1'b0;
			else if (comm_fault)
				dout_nxt[k] = mode_out(fault_mode_r[2*k +: 2], dout[k]);
			else
				dout_nxt[k] = mode_out(idle_mode_r[2*k +: 2], dout[k]);
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			dout <= '0;
			irq <= 1'b0;
		end else begin
			dout <= dout_nxt;
			irq <= irq_nxt;
		end
	end
endmodule : dioc_top

// ===== bench/dioc_top_sva.sv
// assertion checker for the channel conditioning block
`timescale 1ns/100ps
// ==========
// port checks
module dioc_chk #(parameter int N = 8) (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// channels
	input wire logic [N-1:0] dout,
	input wire logic comm_fault,
	input wire logic comm_idle,
	input wire logic irq
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	logic wr;
	logic [8:0] ctrl_r;
	logic [3:0] mask_r;
	logic [N-1:0] od_r, exp_r, exp_nxt;
	logic [2*N-1:0] fm_r, im_r;
	// shadows follow the edge at which the slave takes the write
	assign wr = psel && penable && !pready && pwrite;
	// expected outputs from shadowed settings; hold keeps the current pin level
	always_comb begin
		exp_nxt = od_r;
		for (int i = 0; i < N; i++) begin
			if (comm_fault || comm_idle) begin
				case (comm_fault ? fm_r[2*i+:2] : im_r[2*i+:2])
					2'h1: exp_nxt[i] = dout[i];
					2'h2: exp_nxt[i] = 1'b1;
					default: exp_nxt[i] = 1'b0;
				endcase
				if (!ctrl_r[8]) exp_nxt[i] = 1'b0;
			end
		end
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_r <= 9'h045;
			{mask_r, od_r, exp_r, fm_r, im_r} <= '0;
		end else begin
			exp_r <= exp_nxt;
			if (wr && paddr == 8'h00) ctrl_r <= pwdata[8:0];
			if (wr && paddr == 8'h08) fm_r <= pwdata[2*N-1:0];
			if (wr && paddr == 8'h0C) im_r <= pwdata[2*N-1:0];
			if (wr && paddr == 8'h10) od_r <= pwdata[N-1:0];
			if (wr && paddr == 8'h24) mask_r <= pwdata[3:0];
		end
	end
	sequence s_take; psel && penable && !pready; endsequence
	sequence s_answer; pready ##1 !pready; endsequence
	property p_ready_wait; s_take |=> s_answer; endproperty
	property p_ready_cause; $rose(pready) |-> $past(psel && penable); endproperty
	property p_setup_low; psel && !penable |-> !pready; endproperty
	property p_no_slverr; !pslverr; endproperty
	property p_rdata_hold; !$stable(prdata) |-> pready && !pwrite; endproperty
	property p_dout_mode; dout == exp_r; endproperty
	property p_dout_prio; $past(comm_fault || comm_idle) && !$past(ctrl_r[8]) |-> dout == '0;
	endproperty
	property p_irq_mask; mask_r == 4'h0 && $past(mask_r == 4'h0) |-> !irq; endproperty
	a_ready_wait: assert property (p_ready_wait) else $error("no single wait state");
	a_ready_cause: assert property (p_ready_cause) else $error("ready without access");
	a_setup_low: assert property (p_setup_low) else $error("ready in setup cycle");
	a_no_slverr: assert property (p_no_slverr) else $error("slave error raised");
	a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");
	a_dout_mode: assert property (p_dout_mode) else $error("output mode wrong");
	a_dout_prio: assert property (p_dout_prio) else $error("output not cleared");
	a_irq_mask: assert property (p_irq_mask) else $error("masked interrupt seen");
endmodule : dioc_chk

bind dioc_top dioc_chk #(.N(N)) chk (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .dout(dout), .comm_fault(comm_fault),
	.comm_idle(comm_idle), .irq(irq));

// ===== bench/dioc_field.sv
// field side model: sensors, supplies and output loads
`timescale 1ns/100ps
// ==========
// field model
module dioc_field (
	// actuator drive
	input wire logic [7:0] dout,
	// sensed pins
	output logic [7:0] din_pin,
	output logic supply_short_pin,
	output logic overcur_pin,
	output logic [7:0] load_short_pin,
	output logic [7:0] open_load_pin
);
	logic [7:0] din_r = 8'h00;
	logic [7:0] short_r = 8'h00;
	logic [7:0] open_r = 8'h00;
	logic sup_r = 1'b0;
	logic oc_r = 1'b0;
	assign din_pin = din_r;
	assign supply_short_pin = sup_r;
	assign overcur_pin = oc_r;
	// a short only shows while driven, an open load only while off
	assign load_short_pin = short_r & dout;
	assign open_load_pin = open_r & ~dout;
endmodule : dioc_field

// ===== bench/digital_io_channel_conditioning_test.sv
// self-checking bench for the channel conditioning block
`timescale 1ns/100ps
// ==========
// bench top
module digital_io_channel_conditioning_test;
	logic pclk, presetn, psel, penable, pwrite, comm_fault, comm_idle;
	logic pready, pslverr, irq, supply_short_pin, overcur_pin;
	logic [7:0] paddr, din_pin, load_short_pin, open_load_pin, dout;
	logic [31:0] pwdata, prdata;
	int mismatches = 0;
	int total_checks = 0;
	logic [7:0] zero_regs [6] = '{8'h04, 8'h08, 8'h0C, 8'h10, 8'h24, 8'h28};
	dioc_top #(.FILT0_CYC(4), .FILT1_CYC(8), .EXT0_CYC(4), .EXT3_CYC(32),
		.INRUSH_CYC(50)) uut (.pclk(pclk),
		.presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
		.din_pin(din_pin), .supply_short_pin(supply_short_pin), .overcur_pin(overcur_pin),
		.load_short_pin(load_short_pin), .open_load_pin(open_load_pin), .dout(dout),
		.comm_fault(comm_fault), .comm_idle(comm_idle));
	dioc_field fld (.dout(dout), .din_pin(din_pin), .supply_short_pin(supply_short_pin),
		.overcur_pin(overcur_pin), .load_short_pin(load_short_pin),
		.open_load_pin(open_load_pin));
	initial begin
		pclk = 1'b0;
		forever #4 pclk = ~pclk;
	end
	task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("ERROR %s expected %h seen %h", nm, exp, seen);
		end
	endtask : check
	// one apb transfer; pready and read data are taken at the rising edge where pready stands
	task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		q = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : acc
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		acc(1'b1, a, d, q);
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] q;
		acc(1'b0, a, 32'h0, q);
		check($sformatf("reg %h", a), q, e);
	endtask : rd
	task automatic pins(input logic [7:0] e, input logic ei);
		repeat (2) @(posedge pclk);
		@(negedge pclk);
		check("dout", {24'h0, dout}, {24'h0, e});
		check("irq", {31'h0, irq}, {31'h0, ei});
	endtask : pins
	task automatic final_report;
		if (mismatches == 0 && total_checks > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : final_report
	initial begin
		#100000;
		mismatches++;
		final_report();
	end
	initial begin
		{psel, penable, pwrite, comm_fault, comm_idle, paddr, pwdata} = '0;
		presetn = 1'b0;
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		rd(8'h00, 32'h45);
		wr(8'h00, 32'h47);
		fld.oc_r <= 1'b1;
		repeat (10) @(posedge pclk);
		fld.oc_r <= 1'b0;
		rd(8'h20, 32'h0);
		repeat (60) @(posedge pclk);
		fld.oc_r <= 1'b1;
		repeat (8) @(posedge pclk);
		rd(8'h20, 32'h2);
		fld.oc_r <= 1'b0;
		foreach (zero_regs[i]) rd(zero_regs[i], 32'h0);
		wr(8'h20, 32'hF);
		fld.sup_r <= 1'b1;
		repeat (8) @(posedge pclk);
		rd(8'h20, 32'h1);
		wr(8'h24, 32'h1);
		pins(8'h00, 1'b1);
		@(posedge pclk);
		fld.sup_r <= 1'b0;
		wr(8'h20, 32'h1);
		pins(8'h00, 1'b0);
		wr(8'h00, 32'h46);
		fld.sup_r <= 1'b1;
		repeat (8) @(posedge pclk);
		rd(8'h20, 32'h0);
		fld.sup_r <= 1'b0;
		wr(8'h10, 32'h1);
		wr(8'h00, 32'h06);
		fld.short_r <= 8'h01;
		repeat (8) @(posedge pclk);
		rd(8'h18, 32'h0);
		wr(8'h00, 32'h46);
		repeat (6) @(posedge pclk);
		rd(8'h18, 32'h1);
		fld.short_r <= 8'h00;
		repeat (6) @(posedge pclk);
		rd(8'h18, 32'h0);
		wr(8'h00, 32'hC6);
		fld.short_r <= 8'h01;
		repeat (8) @(posedge pclk);
		fld.short_r <= 8'h00;
		repeat (8) @(posedge pclk);
		rd(8'h18, 32'h1);
		fld.open_r <= 8'h02;
		repeat (8) @(posedge pclk);
		rd(8'h1C, 32'h0);
		wr(8'h04, 32'h2);
		rd(8'h1C, 32'h2);
		fld.open_r <= 8'h00;
		fld.din_r <= 8'h01;
		repeat (3) @(posedge pclk);
		fld.din_r <= 8'h00;
		repeat (20) @(posedge pclk);
		rd(8'h14, 32'h0);
		wr(8'h00, 32'hF2);
		fld.din_r <= 8'h01;
		repeat (20) @(posedge pclk);
		rd(8'h14, 32'h1);
		fld.din_r <= 8'h00;
		repeat (12) @(posedge pclk);
		rd(8'h14, 32'h1);
		repeat (40) @(posedge pclk);
		rd(8'h14, 32'h0);
		wr(8'h10, 32'h3);
		wr(8'h08, 32'h24);
		wr(8'h0C, 32'hD2);
		comm_fault <= 1'b1;
		pins(8'h00, 1'b0);
		@(posedge pclk);
		comm_fault <= 1'b0;
		wr(8'h00, 32'h1F2);
		comm_fault <= 1'b1;
		pins(8'h06, 1'b0);
		@(posedge pclk);
		comm_fault <= 1'b0;
		wr(8'h10, 32'hE);
		comm_idle <= 1'b1;
		pins(8'h05, 1'b0);
		@(posedge pclk);
		comm_idle <= 1'b0;
		presetn <= 1'b0;
		@(posedge pclk);
		presetn <= 1'b1;
		rd(8'h18, 32'h0);
		rd(8'h00, 32'h45);
		pins(8'h00, 1'b0);
		final_report();
	end
endmodule : digital_io_channel_conditioning_test
